//--- pbc_regs.vh
// Index map of the PHY management registers, with control register field positions, write mask and reset value
`ifndef PBC_REGS_VH
`define PBC_REGS_VH
`define PBC_IDX_W         5
`define PBC_IDX_CTRL      5'h00
`define PBC_IDX_STAT      5'h01
`define PBC_IDX_ID1       5'h02
`define PBC_IDX_ID2       5'h03
`define PBC_IDX_ADV       5'h04
`define PBC_IDX_LPA       5'h05
`define PBC_IDX_EXP       5'h06
`define PBC_IDX_ENDET     5'h10
`define PBC_IDX_MODE      5'h11
`define PBC_IDX_SMODE     5'h12
`define PBC_IDX_SYMERR    5'h1a
`define PBC_IDX_SIND      5'h1b
`define PBC_IDX_ISRC      5'h1d
`define PBC_IDX_IMASK     5'h1e
`define PBC_IDX_SCS       5'h1f
`define PBC_NSEL          15
`define PBC_BIT_RST       15
`define PBC_BIT_LOOP      14
`define PBC_BIT_SPEED     13
`define PBC_BIT_ANEN      12
`define PBC_BIT_PDN       11
`define PBC_BIT_ANRST     9
`define PBC_BIT_DUPLEX    8
`define PBC_BIT_COLTEST   7
`define PBC_CTRL_RESET    16'h3000
`define PBC_CTRL_WMASK    16'hfb80
`define PBC_SRST_CYCLES   8
`endif

//--- pbc_index_dec.v
// Index decoder for the indirectly reached PHY register set
`default_nettype none
module pbc_index_dec (
  // Register index from the management access path
  input  wire [4:0]  idx_in,
  // One-hot select, bit order as the index map below
  output reg  [14:0] sel_out,
  output reg         hit_out
);
`include "pbc_regs.vh"
  // Pure decode; registered by the caller
  always @* begin
    sel_out = 15'h0000;
    case (idx_in)
      `PBC_IDX_CTRL:   sel_out[0]  = 1'b1;
      `PBC_IDX_STAT:   sel_out[1]  = 1'b1;
      `PBC_IDX_ID1:    sel_out[2]  = 1'b1;
      `PBC_IDX_ID2:    sel_out[3]  = 1'b1;
      `PBC_IDX_ADV:    sel_out[4]  = 1'b1;
      `PBC_IDX_LPA:    sel_out[5]  = 1'b1;
      `PBC_IDX_EXP:    sel_out[6]  = 1'b1;
      `PBC_IDX_ENDET:  sel_out[7]  = 1'b1;
      `PBC_IDX_MODE:   sel_out[8]  = 1'b1;
      `PBC_IDX_SMODE:  sel_out[9]  = 1'b1;
      `PBC_IDX_SYMERR: sel_out[10] = 1'b1;
      `PBC_IDX_SIND:   sel_out[11] = 1'b1;
      `PBC_IDX_ISRC:   sel_out[12] = 1'b1;
      `PBC_IDX_IMASK:  sel_out[13] = 1'b1;
      `PBC_IDX_SCS:    sel_out[14] = 1'b1;
      default:         sel_out = 15'h0000;
    endcase
    hit_out = |sel_out;
  end
endmodule
`default_nettype wire

//--- pbc_ctrl.v
// PHY basic control register and index map, reached by indexed management access
//
// Contract
// - PHY registers are reached only by index through the MAC management path.
// - Decode indices 0-6 and 16 to their registers.
// - Decode indices 17,18,26,27,29,30,31 to their registers.
// - Basic control register is 16 bits at index 0.
// - Writing bit 15 starts soft reset; self-clears; PHY returns to normal.
// - Kept-through-soft-reset fields survive only a soft reset.
// - Bit 14 selects loopback, resets to 0.
// - Bit 13 selects 100 Mbps, resets to 1, ignored while autoneg on.
// - Bit 12 enables autoneg, resets to 1, overrides speed and duplex.
// - Bit 11 selects general power down, resets to 0.
// - Bit 9 restarts autoneg, self-clears, reads 0.
// - Bit 8 selects full duplex, resets to 0, ignored while autoneg on.
// - Bit 7 enables collision test, resets to 0.
`default_nettype none
`include "pbc_regs.vh"
module pbc_ctrl #(
  // Soft reset length in clock cycles, 1 to 255
  parameter SRST_CYCLES = `PBC_SRST_CYCLES
) (
  // Clock and reset
  input  wire        CLK_IN,
  input  wire        NRST_IN,
  // Indexed management access
  input  wire        ACC_VALID_IN,
  input  wire        ACC_WRITE_IN,
  input  wire [4:0]  ACC_INDEX_IN,
  input  wire [15:0] ACC_WDATA_IN,
  output reg         ACC_DONE_OUT,
  output reg  [15:0] ACC_RDATA_OUT,
  output reg  [14:0] ACC_SEL_OUT,
  output reg         ACC_HIT_OUT,
  // Negotiated result from the autoneg engine
  input  wire        AN_SPEED100_IN,
  input  wire        AN_FULLDUP_IN,
  // Kept-through-soft-reset field written by other register logic
  input  wire        KEEP_WR_IN,
  input  wire [15:0] KEEP_WDATA_IN,
  // Controls to the PHY core
  output reg         SOFT_RST_OUT,
  output reg         LOOPBACK_OUT,
  output reg         SPEED100_OUT,
  output reg         FULLDUP_OUT,
  output reg         AN_EN_OUT,
  output reg         AN_RESTART_OUT,
  output reg         POWER_DOWN_OUT,
  output reg         COL_TEST_OUT,
  output reg  [15:0] KEPT_THROUGH_SOFT_RESET_OUT
);

  // Index decoder results
  wire [14:0] sel;
  wire        hit;

  // Stored control bits and the next value
  reg  [15:0] ctrl_r;
  reg  [15:0] ctrl_nxt;

  // Field that only a hardware reset clears
  reg  [15:0] keep_r;

  // Soft reset timer and flag
  reg  [7:0]  srst_cnt_r;
  reg         srst_r;

  // Restart request held for one cycle
  reg         anrst_r;

  // Index 0 match; shared by the write and read paths
  function is_ctrl_index;
    input [4:0] idx;
    begin
      is_ctrl_index = (idx == `PBC_IDX_CTRL);
    end
  endfunction

  pbc_index_dec u_dec (
    .idx_in  (ACC_INDEX_IN),
    .sel_out (sel),
    .hit_out (hit)
  );

  // Access qualifiers
  wire acc_ctrl = ACC_VALID_IN & is_ctrl_index(ACC_INDEX_IN);
  wire wr_ctrl  = acc_ctrl & ACC_WRITE_IN;
  wire rd_ctrl  = acc_ctrl & ~ACC_WRITE_IN;

  // reset wins even if other bits are set
  wire srst_req = wr_ctrl & ACC_WDATA_IN[`PBC_BIT_RST];

  // restart dropped when reset comes in the same write
  wire anrst_req = wr_ctrl & ~srst_req & ACC_WDATA_IN[`PBC_BIT_ANRST];

  // Timer state decode
  wire srst_busy = (srst_cnt_r != 8'h00);
  wire srst_last = (srst_cnt_r == 8'h01);

  wire an_on     = ctrl_r[`PBC_BIT_ANEN];
  wire speed_sel = an_on ? AN_SPEED100_IN : ctrl_r[`PBC_BIT_SPEED];
  wire dup_sel   = an_on ? AN_FULLDUP_IN : ctrl_r[`PBC_BIT_DUPLEX];

  // Read word; bit 15 reads 1 while reset is in progress
  wire [15:0] rd_word = ctrl_r | {srst_r, 15'h0000};

  // Next value; reset write loads defaults, others store writable bits
  always @* begin
    ctrl_nxt = ctrl_r;
    // soft reset returns control to normal
    if (srst_req) begin
      ctrl_nxt = `PBC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_nxt = ACC_WDATA_IN & `PBC_CTRL_WMASK;
    end
    ctrl_nxt[`PBC_BIT_ANRST] = 1'b0;
    // Reset bit lives in the timer, not here
    ctrl_nxt[`PBC_BIT_RST] = 1'b0;
  end

  // Control register
  // Power down with autoneg on is not blocked; software duty
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      ctrl_r <= `PBC_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      anrst_r <= 1'b0;
    end else begin
      anrst_r <= anrst_req;
    end
  end

  // self-clearing soft reset window
  // A new reset write during the window starts it again
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      srst_cnt_r <= 8'h00;
      srst_r     <= 1'b0;
    end else if (srst_req) begin
      srst_cnt_r <= SRST_CYCLES[7:0];
      srst_r     <= 1'b1;
    end else if (srst_busy) begin
      srst_cnt_r <= srst_cnt_r - 8'h01;
      srst_r     <= ~srst_last;
    end
  end

  // kept field cleared by hardware reset only, not soft reset
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      keep_r <= 16'h0000;
    end else if (KEEP_WR_IN) begin
      // Loaded by the owning register logic
      keep_r <= KEEP_WDATA_IN;
    end
  end

  // Access answer; data, select and hit stand for one cycle
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      ACC_DONE_OUT  <= 1'b0;
      ACC_RDATA_OUT <= 16'h0000;
      ACC_SEL_OUT   <= 15'h0000;
      ACC_HIT_OUT   <= 1'b0;
    end else begin
      // access only through the indexed port
      ACC_DONE_OUT  <= ACC_VALID_IN;
      // Select and hit only with a request
      ACC_SEL_OUT   <= ACC_VALID_IN ? sel : 15'h0000;
      ACC_HIT_OUT   <= ACC_VALID_IN & hit;
      // 16-bit read of index 0, zero elsewhere
      ACC_RDATA_OUT <= rd_ctrl ? rd_word : 16'h0000;
    end
  end

  // Control levels to the PHY core; one cycle behind the register
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      SOFT_RST_OUT   <= 1'b0;
      LOOPBACK_OUT   <= 1'b0;
      SPEED100_OUT   <= 1'b1;
      FULLDUP_OUT    <= 1'b0;
      AN_EN_OUT      <= 1'b1;
      AN_RESTART_OUT <= 1'b0;
      POWER_DOWN_OUT <= 1'b0;
      COL_TEST_OUT   <= 1'b0;
      KEPT_THROUGH_SOFT_RESET_OUT <= 16'h0000;
    end else begin
      // Soft reset flag to the core
      SOFT_RST_OUT   <= srst_r;
      LOOPBACK_OUT   <= ctrl_r[`PBC_BIT_LOOP];
      SPEED100_OUT   <= speed_sel;
      FULLDUP_OUT    <= dup_sel;
      // Autoneg enable and restart
      AN_EN_OUT      <= an_on;
      AN_RESTART_OUT <= anrst_r;
      POWER_DOWN_OUT <= ctrl_r[`PBC_BIT_PDN];
      COL_TEST_OUT   <= ctrl_r[`PBC_BIT_COLTEST];
      // Kept field copy
      KEPT_THROUGH_SOFT_RESET_OUT <= keep_r;
    end
  end
endmodule
`default_nettype wire

//--- pbc_ctrl_assertions.sv
// Port-level assertions for the PHY basic control register
`default_nettype none
module pbc_ctrl_chk #(parameter SRST_CYCLES = 8) (
  input wire logic        CLK_IN, NRST_IN, ACC_VALID_IN, ACC_WRITE_IN, ACC_DONE_OUT, ACC_HIT_OUT,
  input wire logic        AN_SPEED100_IN, SOFT_RST_OUT, LOOPBACK_OUT, AN_EN_OUT, AN_RESTART_OUT,
  input wire logic        POWER_DOWN_OUT, SPEED100_OUT,
  input wire logic [4:0]  ACC_INDEX_IN,
  input wire logic [14:0] ACC_SEL_OUT,
  input wire logic [15:0] ACC_WDATA_IN, ACC_RDATA_OUT, KEPT_THROUGH_SOFT_RESET_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // Write aimed at index 0
  wire w0 = ACC_VALID_IN && ACC_WRITE_IN && ACC_INDEX_IN == 5'h00;
  a_done_follows: assert property (ACC_VALID_IN |=> ACC_DONE_OUT) else $error("done missing");
  a_reserved_read: assert property (ACC_DONE_OUT |-> (ACC_RDATA_OUT & 16'h067f) == 16'h0000) else $error("rsv");
  a_unmapped_zero: assert property (ACC_DONE_OUT && !ACC_HIT_OUT |-> ACC_SEL_OUT == 15'h0000) else $error("sel");
  a_restart_pulse: assert property (w0 && ACC_WDATA_IN[9] && !ACC_WDATA_IN[15]
    |-> ##2 AN_RESTART_OUT ##1 !AN_RESTART_OUT) else $error("restart");
  a_speed_auto: assert property (AN_EN_OUT && $past(NRST_IN) && $stable(AN_SPEED100_IN)
    |-> SPEED100_OUT == AN_SPEED100_IN) else $error("speed");
  a_srst_len: assert property (w0 && ACC_WDATA_IN[15] |-> ##2 SOFT_RST_OUT[*8] ##1 !SOFT_RST_OUT) else $error("srst");
  a_srst_clears: assert property (w0 && ACC_WDATA_IN[15]
    |-> ##2 !LOOPBACK_OUT && AN_EN_OUT && !POWER_DOWN_OUT) else $error("srst val");
  a_loop_write: assert property (w0 && !ACC_WDATA_IN[15]
    |-> ##2 LOOPBACK_OUT == $past(ACC_WDATA_IN[14], 2)) else $error("loop");
  a_kept_hold: assert property (SOFT_RST_OUT |-> $stable(KEPT_THROUGH_SOFT_RESET_OUT)) else $error("kept");
  c_srst: cover property (SOFT_RST_OUT);
  c_miss: cover property (ACC_DONE_OUT && !ACC_HIT_OUT);
  c_rst: cover property (AN_RESTART_OUT);
endmodule
bind pbc_ctrl pbc_ctrl_chk #(.SRST_CYCLES(SRST_CYCLES)) chk (.*);
`default_nettype wire

//--- pbc_mac_model.sv
// Management access master standing in for the MAC side
`default_nettype none
module pbc_mac_model (
  input wire logic        clk,
  output logic            vld, wen,
  output logic [4:0]      idx,
  output logic [15:0]     wd,
  input wire logic [15:0] rdat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {vld, wen, idx, wd} = '0;
  // indexed access only; data inverted once released
  task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    {vld, wen, idx, wd} <= {1'b1, w, i, d};
    @(posedge clk);
    vld <= 0;
    wd <= ~d;
    @(posedge clk);
    q = rdat;
  endtask
endmodule
`default_nettype wire

//--- phy_basic_control_regs_test.sv
// Self-checking bench for the PHY basic control register bank
`default_nettype none
module phy_basic_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, kw = 0, asp = 1, afd = 0, vld, wen, done, hit, sr, lb, sp, fd, ae, ar, pd, ct;
  logic [4:0] idx;
  logic [14:0] sel, ex;
  logic [15:0] wd, rd, kept, q, kd = 16'h0000;
  int err_count = 0, cmp_count = 0;
  byte mp[15] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 18, 26, 27, 29, 30, 31};
  always #12.5 clk = ~clk;
  pbc_ctrl uut (.CLK_IN(clk), .NRST_IN(nrst), .ACC_VALID_IN(vld), .ACC_WRITE_IN(wen), .ACC_INDEX_IN(idx),
    .ACC_WDATA_IN(wd), .ACC_DONE_OUT(done), .ACC_RDATA_OUT(rd), .ACC_SEL_OUT(sel), .ACC_HIT_OUT(hit),
    .AN_SPEED100_IN(asp), .AN_FULLDUP_IN(afd), .KEEP_WR_IN(kw), .KEEP_WDATA_IN(kd), .SOFT_RST_OUT(sr),
    .LOOPBACK_OUT(lb), .SPEED100_OUT(sp), .FULLDUP_OUT(fd), .AN_EN_OUT(ae), .AN_RESTART_OUT(ar),
    .POWER_DOWN_OUT(pd), .COL_TEST_OUT(ct), .KEPT_THROUGH_SOFT_RESET_OUT(kept));
  pbc_mac_model mac (.clk(clk), .vld(vld), .wen(wen), .idx(idx), .wd(wd), .rdat(rd));
  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, a);
    cmp_count++;
    if (a !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, well beyond the roughly 150 cycles needed
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    conclude;
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    mac.acc(0, 5'h00, 16'h0000, q); chk("reset", 16'h3000, q);
    $display("reset values done");
    // Autoneg cleared so the written speed and duplex bits reach the outputs
    mac.acc(1, 5'h00, 16'h0000, q);
    mac.acc(1, 5'h00, 16'h6dff, q);
    mac.acc(0, 5'h00, 16'h0000, q); chk("fields", 16'h6980, q);
    chk("outs", 16'h0037, {10'h000, lb, sp, ae, pd, fd, ct});
    $display("field write done");
    asp <= 0;
    afd <= 1;
    mac.acc(1, 5'h00, 16'h1000, q);
    mac.acc(0, 5'h00, 16'h0000, q); chk("auto", 16'h0001, {14'h0000, sp, fd});
    $display("autoneg override done");
    kd <= 16'ha5c3;
    kw <= 1;
    @(posedge clk) kw <= 0;
    mac.acc(1, 5'h00, 16'h8000, q);
    mac.acc(0, 5'h00, 16'h0000, q); chk("srst", 16'hb000, q);
    repeat (10) @(posedge clk);
    mac.acc(0, 5'h00, 16'h0000, q); chk("after", 16'h3000, q);
    chk("kept", 16'ha5c3, kept);
    $display("soft reset done");
    for (int i = 0; i < 32; i++) begin
      ex = '0;
      foreach (mp[k]) if (mp[k] == i) ex[k] = 1;
      mac.acc(0, i[4:0], 16'h0000, q); chk("map", {ex != 0, ex}, {hit, sel});
    end
    $display("index map done");
    nrst <= 0;
    repeat (2) @(posedge clk) nrst <= 1;
    mac.acc(0, 5'h00, 16'h0000, q); chk("hard", 16'h3000, q);
    chk("kept0", 16'h0000, kept);
    $display("hard reset done");
    conclude;
  end
endmodule
`default_nettype wire
